// ### bench/tb_top.sv
`timescale 1ns/1ns
`include "cpmc_defines.svh"
// Drives the mode controller directly and checks it against a bench model
module tb_top import cpmc_pkg::*; ;
  logic clk_sys = 0;
  logic srst = 1;
  logic lifecycle_done = 0;
  logic test_disable_req = 0;
  logic grant_wr = 0;
  logic [7:0] grant_wdata = 8'h00;
  cpmc_vec_t vec_req = '0;
  cpmc_acc_t acc_req = '0;
  cpmc_mode_t cpu_mode;
  logic super_mode, jump_vld, acc_ok, acc_deny, test_locked;
  logic [15:0] jump_addr;
  logic [7:0] grant_mask;
  int num_errors = 0;
  int tests_run = 0;
  cpmc_ctrl cpmc_ctrl_i (.clk_sys(clk_sys), .srst(srst), .lifecycle_done(lifecycle_done),
    .test_disable_req(test_disable_req), .vec_req(vec_req), .acc_req(acc_req), .grant_wr(grant_wr),
    .grant_wdata(grant_wdata), .cpu_mode(cpu_mode), .super_mode(super_mode), .jump_vld(jump_vld),
    .jump_addr(jump_addr), .acc_ok(acc_ok), .acc_deny(acc_deny), .grant_mask(grant_mask),
    .test_locked(test_locked));
  // 100 MHz clock
  always #5 clk_sys = ~clk_sys;
  task automatic cmp1(string n, logic e, logic g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : cmp1
  task automatic cmpm(string n, cpmc_mode_t e, cpmc_mode_t g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : cmpm
  task automatic cmpv(string n, logic [15:0] e, logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : cmpv
  // Priority model: exception, interrupt, firmware call, system call, return to user
  function automatic void exp_vec(input cpmc_vec_t v, inout cpmc_mode_t m, output logic ev, inout logic [15:0] ea);
    ev = 1'b1;
    if (v.exc_vld) begin
      ea = `CPMC_EXC_BASE + 16'(v.exc_id);
      m = CPMC_SYS;
    end else if (v.irq_vld) begin
      ea = `CPMC_IRQ_BASE + 16'(v.irq_id);
      m = CPMC_SYS;
    end else if (v.fw_call) begin
      ea = `CPMC_FIRMWARE_CALL_VECTOR_BASE + 16'(v.fw_id);
      m = CPMC_FW;
    end else if (v.sys_call) begin
      ea = `CPMC_SYSTEM_CALL_VECTOR_BASE + 16'(v.sys_id);
      m = CPMC_SYS;
    end else begin
      ev = 1'b0;
      if (v.ret_user && m != CPMC_TEST) m = CPMC_USER;
    end
  endfunction : exp_vec
  // User sees granted groups plus the default one; firmware only granted ones
  function automatic logic exp_acc(cpmc_mode_t m, logic [7:0] g, cpmc_acc_t a);
    case (m)
      CPMC_USER: return a.valid && !a.sys_only && |(a.grp_onehot & (g | `CPMC_USER_DFLT));
      CPMC_FW: return a.valid && !a.sys_only && |(a.grp_onehot & g);
      default: return a.valid;
    endcase
  endfunction : exp_acc
  // Reset, try a firmware call during boot, then wait for the boot exit jump
  task automatic do_reset(logic [15:0] ea, cpmc_mode_t em);
    int k;
    @(posedge clk_sys);
    #1 srst = 1;
    repeat (2) @(posedge clk_sys);
    #1 srst = 0;
    cmpm("boot_mode", CPMC_BOOT, cpu_mode);
    cmp1("boot_super", 1'b1, super_mode);
    cmpv("grant_rst", 16'h0000, {8'h00, grant_mask});
    vec_req = '0;
    vec_req.fw_call = 1'b1;
    k = 0;
    while (jump_vld !== 1'b1 && k < 20) begin
      @(posedge clk_sys);
      #1 k++;
    end
    cmpv("boot_exit_addr", ea, jump_addr);
    cmpm("boot_exit_mode", em, cpu_mode);
    vec_req = '0;
    $display("test reset done");
  endtask : do_reset
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict
  // Watchdog against a hung run
  initial begin
    #50000;
    num_errors++;
    give_verdict();
  end
  initial begin
    cpmc_mode_t m;
    logic [7:0] g;
    logic [15:0] ea;
    logic ev, ok;
    cpmc_vec_t v;
    cpmc_acc_t a;
    void'($urandom(32'hfd10));
    do_reset(`CPMC_TEST_ENTRY, CPMC_TEST);
    vec_req.ret_user = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1 cmpm("test_hold", CPMC_TEST, cpu_mode);
    vec_req = '0;
    test_disable_req = 1'b1;
    repeat (6) @(posedge clk_sys);
    #1 test_disable_req = 1'b0;
    repeat (4) @(posedge clk_sys);
    #1 cmp1("lock_set", 1'b1, test_locked);
    cmpm("test_abandon", CPMC_SYS, cpu_mode);
    do_reset(`CPMC_SYS_ENTRY, CPMC_SYS);
    cmp1("lock_kept", 1'b1, test_locked);
    m = CPMC_SYS;
    g = 8'h00;
    ea = `CPMC_SYS_ENTRY;
    // Random vectors, accesses and grant writes, corner cases first
    for (int i = 0; i < 300; i++) begin
      v = cpmc_vec_t'(21'($urandom));
      v.exc_vld = (i == 0) || ($urandom_range(0, 9) == 0);
      v.irq_vld = (i == 0) || ($urandom_range(0, 9) == 0);
      v.fw_call = (i < 2) || ($urandom_range(0, 7) == 0);
      v.sys_call = (i < 3) || ($urandom_range(0, 7) == 0);
      v.ret_user = $urandom_range(0, 3) == 0;
      if (i < 3) {v.fw_id, v.sys_id} = 8'hff;
      a.valid = $urandom_range(0, 7) != 0;
      a.grp_onehot = 8'h01 << $urandom_range(0, 7);
      a.sys_only = $urandom_range(0, 3) == 0;
      vec_req = v;
      acc_req = a;
      grant_wr = $urandom_range(0, 2) == 0;
      grant_wdata = 8'($urandom);
      #1 ok = exp_acc(m, g, a);
      cmp1("acc_ok", ok, acc_ok);
      cmp1("acc_deny", a.valid && !ok, acc_deny);
      if (grant_wr && m == CPMC_SYS) g = grant_wdata;
      exp_vec(v, m, ev, ea);
      @(posedge clk_sys);
      #1 cmpm("mode", m, cpu_mode);
      cmp1("super", m == CPMC_FW, super_mode);
      cmp1("jump_vld", ev, jump_vld);
      cmpv("jump_addr", ea, jump_addr);
      cmpv("grant", {8'h00, g}, {8'h00, grant_mask});
    end
    vec_req = '0;
    acc_req = '0;
    grant_wr = 1'b0;
    $display("test random done");
    lifecycle_done = 1'b1;
    do_reset(`CPMC_SYS_ENTRY, CPMC_SYS);
    give_verdict();
  end
endmodule : tb_top

// ### rtl/cpmc_ctrl.sv
`timescale 1ns/1ns
`include "cpmc_defines.svh"
module cpmc_ctrl
  import cpmc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic lifecycle_done,
  input wire logic test_disable_req,
  input wire cpmc_vec_t vec_req,
  input wire cpmc_acc_t acc_req,
  input wire logic grant_wr,
  input wire logic [`CPMC_GRP_W-1:0] grant_wdata,
  output cpmc_mode_t cpu_mode,
  output logic super_mode,
  output logic jump_vld,
  output logic [`CPMC_ADDR_W-1:0] jump_addr,
  output logic acc_ok,
  output logic acc_deny,
  output logic [`CPMC_GRP_W-1:0] grant_mask,
  output logic test_locked
);
  // Boot counter and state held as one struct
  typedef struct packed {
    cpmc_mode_t mode;
    logic [3:0] boot_cnt;
    logic lock;
    logic lock_seen;
    logic [`CPMC_GRP_W-1:0] grant;
    logic jv;
    logic [`CPMC_ADDR_W-1:0] ja;
  } cpmc_st_t;
  cpmc_st_t st_r;
  cpmc_st_t st_nxt;
  logic life_s; // Synchronised lifecycle pin
  logic tdis_s; // Synchronised fuse-blow request
  logic grp_hit; // Access targets a granted group

  // Pins from outside pass through synchronisers
  cpmc_sync3 u_sync_life (
    .clk_sys(clk_sys),
    .srst(srst),
    .din(lifecycle_done),
    .dout(life_s)
  );
  cpmc_sync3 u_sync_tdis (
    .clk_sys(clk_sys),
    .srst(srst),
    .din(test_disable_req),
    .dout(tdis_s)
  );

  // Group grant check for firmware accesses; the user check also admits the default group
  assign grp_hit = (acc_req.grp_onehot & ~st_r.grant) == '0;

  // Next-state logic
  always_comb begin
    st_nxt = st_r;
    st_nxt.jv = 1'b0;
    // Sticky lock: only set, never cleared by logic; models a fuse.
    if (life_s || tdis_s) begin
      st_nxt.lock = 1'b1;
    end
    case (st_r.mode)
      CPMC_BOOT: begin
        // Let the synchronisers settle before choosing the exit mode
        if (st_r.boot_cnt != `CPMC_BOOT_CYC) begin
          st_nxt.boot_cnt = st_r.boot_cnt + 4'h1;
        end else if (st_r.lock || life_s) begin
          st_nxt.mode = CPMC_SYS;
          st_nxt.jv = 1'b1;
          st_nxt.ja = `CPMC_SYS_ENTRY;
        end else begin
          st_nxt.mode = CPMC_TEST;
          st_nxt.jv = 1'b1;
          st_nxt.ja = `CPMC_TEST_ENTRY;
        end
      end
      CPMC_TEST, CPMC_FW, CPMC_SYS, CPMC_USER: begin
        // Priority: exception, interrupt, firmware call, system call, return
        if (vec_req.exc_vld) begin
          st_nxt.mode = CPMC_SYS;
          st_nxt.jv = 1'b1;
          st_nxt.ja = `CPMC_EXC_BASE + {12'h000, vec_req.exc_id};
        end else if (vec_req.irq_vld) begin
          st_nxt.mode = CPMC_SYS;
          st_nxt.jv = 1'b1;
          st_nxt.ja = `CPMC_IRQ_BASE + {12'h000, vec_req.irq_id};
        end else if (vec_req.fw_call) begin
          st_nxt.mode = CPMC_FW;
          st_nxt.jv = 1'b1;
          st_nxt.ja = `CPMC_FIRMWARE_CALL_VECTOR_BASE + {13'h0000, vec_req.fw_id};
        end else if (vec_req.sys_call) begin
          st_nxt.mode = CPMC_SYS;
          st_nxt.jv = 1'b1;
          st_nxt.ja = `CPMC_SYSTEM_CALL_VECTOR_BASE + {11'h000, vec_req.sys_id};
        end else if (vec_req.ret_user && st_r.mode != CPMC_TEST) begin
          // Dropping privilege never raises it; test stays put
          st_nxt.mode = CPMC_USER;
        end
        // Test mode is abandoned once locked
        if (st_r.mode == CPMC_TEST && st_r.lock) begin
          st_nxt.mode = CPMC_SYS;
        end
      end
      default: begin
        st_nxt.mode = CPMC_BOOT;
      end
    endcase
    // Grant register written by system mode only
    if (grant_wr && st_r.mode == CPMC_SYS) begin
      st_nxt.grant = grant_wdata;
    end
  end

  // Registers; lock survives srst as a fuse would, and no reset clears it
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_r.mode <= CPMC_BOOT;
      st_r.boot_cnt <= 4'h0;
      st_r.grant <= `CPMC_GRP_GRANT_RST;
      st_r.jv <= 1'b0;
      st_r.ja <= `CPMC_BOOT_ENTRY;
      st_r.lock <= st_r.lock;
      st_r.lock_seen <= 1'b1;
    end else begin
      st_r <= st_nxt;
      st_r.lock_seen <= 1'b1;
    end
  end

  // Access decision per mode
  always_comb begin
    acc_ok = 1'b0;
    if (acc_req.valid) begin
      case (st_r.mode)
        CPMC_SYS: acc_ok = 1'b1;
        CPMC_BOOT, CPMC_TEST: acc_ok = 1'b1;
        CPMC_FW: acc_ok = !acc_req.sys_only && grp_hit;
        CPMC_USER: acc_ok = !acc_req.sys_only &&
          ((acc_req.grp_onehot & ~(st_r.grant | `CPMC_USER_DFLT)) == '0);
        default: acc_ok = 1'b0;
      endcase
    end
  end
  assign acc_deny = acc_req.valid && !acc_ok;

  assign cpu_mode = st_r.mode;
  assign super_mode = (st_r.mode == CPMC_BOOT) || (st_r.mode == CPMC_TEST) || (st_r.mode == CPMC_FW);
  assign jump_vld = st_r.jv;
  assign jump_addr = st_r.ja;
  assign grant_mask = st_r.grant;
  assign test_locked = st_r.lock;

  // Checks
  mode_legal_a: assert property (@(posedge clk_sys) disable iff (srst)
    cpu_mode inside {CPMC_BOOT, CPMC_TEST, CPMC_FW, CPMC_SYS, CPMC_USER})
    else $error("illegal mode");
  super_one_a: assert property (@(posedge clk_sys) disable iff (srst)
    super_mode |-> cpu_mode inside {CPMC_BOOT, CPMC_TEST, CPMC_FW})
    else $error("super mode mismatch");
  fw_entry_a: assert property (@(posedge clk_sys) disable iff (srst)
    (cpu_mode == CPMC_FW && $past(cpu_mode) != CPMC_FW && $past(cpu_mode) != CPMC_BOOT) |->
    $past(vec_req.fw_call))
    else $error("firmware entered without call");
  test_exit_a: assert property (@(posedge clk_sys) disable iff (srst)
    (cpu_mode == CPMC_BOOT && st_r.boot_cnt == `CPMC_BOOT_CYC && !st_r.lock && !life_s)
    |=> cpu_mode == CPMC_TEST)
    else $error("boot did not enter test");
  lock_sticky_a: assert property (@(posedge clk_sys)
    $past(test_locked) && st_r.lock_seen |-> test_locked)
    else $error("lock cleared");
  sys_exit_a: assert property (@(posedge clk_sys) disable iff (srst)
    (cpu_mode == CPMC_BOOT && st_r.boot_cnt == `CPMC_BOOT_CYC && st_r.lock)
    |=> cpu_mode == CPMC_SYS ##0 jump_addr == `CPMC_SYS_ENTRY)
    else $error("boot did not enter system");
  sys_full_a: assert property (@(posedge clk_sys) disable iff (srst)
    (acc_req.valid && cpu_mode == CPMC_SYS) |-> acc_ok)
    else $error("system access denied");
  user_gate_a: assert property (@(posedge clk_sys) disable iff (srst)
    (acc_req.valid && cpu_mode == CPMC_USER && acc_req.sys_only) |-> acc_deny)
    else $error("user reached system-only");
  fw_gate_a: assert property (@(posedge clk_sys) disable iff (srst)
    (acc_req.valid && cpu_mode == CPMC_FW && (acc_req.grp_onehot & ~grant_mask) != '0)
    |-> !acc_ok)
    else $error("firmware bypassed grant");
  fcall_a: assert property (@(posedge clk_sys) disable iff (srst)
    (cpu_mode != CPMC_BOOT && !vec_req.exc_vld && !vec_req.irq_vld && vec_req.fw_call &&
    !(cpu_mode == CPMC_TEST && test_locked))
    |=> cpu_mode == CPMC_FW && jump_vld)
    else $error("firmware call missed");
  scall_a: assert property (@(posedge clk_sys) disable iff (srst)
    (cpu_mode != CPMC_BOOT && !vec_req.exc_vld && !vec_req.irq_vld && !vec_req.fw_call && vec_req.sys_call)
    |=> cpu_mode == CPMC_SYS && jump_addr[15:8] == 8'h01)
    else $error("system call missed");
  exc_vec_a: assert property (@(posedge clk_sys) disable iff (srst)
    (cpu_mode != CPMC_BOOT && vec_req.exc_vld) |=> jump_vld && jump_addr[15:4] == 12'h000)
    else $error("exception vector wrong");
  cov_test_c: cover property (@(posedge clk_sys) cpu_mode == CPMC_TEST);
  cov_fw_c: cover property (@(posedge clk_sys) cpu_mode == CPMC_FW ##1 cpu_mode == CPMC_USER);
  cov_user_c: cover property (@(posedge clk_sys) cpu_mode == CPMC_USER && acc_ok);
endmodule : cpmc_ctrl

// ### rtl/cpmc_defines.svh
`ifndef CPMC_DEFINES_SVH
`define CPMC_DEFINES_SVH
// Mode encodings
`define CPMC_MODE_BOOT 3'h0
`define CPMC_MODE_TEST 3'h1
`define CPMC_MODE_FW 3'h2
`define CPMC_MODE_SYS 3'h3
`define CPMC_MODE_USER 3'h4
// Vector counts and widths
`define CPMC_FIRMWARE_CALL_VECTOR_NUM 8
`define CPMC_SYSTEM_CALL_VECTOR_NUM 32
`define CPMC_FIRMWARE_CALL_VECTOR_W 3
`define CPMC_SYSTEM_CALL_VECTOR_W 5
`define CPMC_EXC_W 4
`define CPMC_IRQ_W 4
// Vector address layout
`define CPMC_ADDR_W 16
`define CPMC_EXC_BASE 16'h0000
`define CPMC_IRQ_BASE 16'h0040
`define CPMC_FIRMWARE_CALL_VECTOR_BASE 16'h0080
`define CPMC_SYSTEM_CALL_VECTOR_BASE 16'h0100
`define CPMC_BOOT_ENTRY 16'h8000
`define CPMC_TEST_ENTRY 16'h9000
`define CPMC_SYS_ENTRY 16'h1000
// Grantable peripheral group width
`define CPMC_GRP_W 8
`define CPMC_GRP_GRANT_RST 8'h00
// Default user-visible group mask
`define CPMC_USER_DFLT 8'h01
// Boot counter terminal count; boot mode lasts one cycle longer than this
`define CPMC_BOOT_CYC 4'h4
`endif

// ### rtl/cpmc_pkg.sv
`include "cpmc_defines.svh"
package cpmc_pkg;
  // CPU mode
  typedef enum logic [2:0] {
    CPMC_BOOT = 3'b000,
    CPMC_TEST = 3'b001,
    CPMC_FW = 3'b010,
    CPMC_SYS = 3'b011,
    CPMC_USER = 3'b100
  } cpmc_mode_t;
  // Register access request from the core
  typedef struct packed {
    logic valid;
    logic [`CPMC_GRP_W-1:0] grp_onehot;
    logic sys_only;
  } cpmc_acc_t;
  // Vector jump request
  typedef struct packed {
    logic exc_vld;
    logic [`CPMC_EXC_W-1:0] exc_id;
    logic irq_vld;
    logic [`CPMC_IRQ_W-1:0] irq_id;
    logic fw_call;
    logic [`CPMC_FIRMWARE_CALL_VECTOR_W-1:0] fw_id;
    logic sys_call;
    logic [`CPMC_SYSTEM_CALL_VECTOR_W-1:0] sys_id;
    logic ret_user;
  } cpmc_vec_t;
endpackage : cpmc_pkg

// ### rtl/cpmc_sync3.sv
`timescale 1ns/1ns
// Three-stage input synchroniser; output moves when stages two and three agree
module cpmc_sync3
  import cpmc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic din,
  output logic dout
);
  // All flops of this module as one struct
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic q;
  } cpmc_sync_st_t;
  cpmc_sync_st_t st_r;
  cpmc_sync_st_t st_nxt;
  // Next state; s1 feeds only s2
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = din;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    if (st_r.s2 == st_r.s3) begin
      st_nxt.q = st_r.s3;
    end
  end
  // Registers
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign dout = st_r.q;
endmodule : cpmc_sync3
